// ---- shared/spms_pkg.sv ----
// Purpose: Shared constants for the byte-wide SPI master/slave port.
// Assumes: An 8-bit special-function register bus with one-cycle strobes.
// Notes: Field positions refer to the control register; reset values are byte wide.

package spms_pkg;

    localparam logic [7:0] SPMS_ADDR_DATA = 8'hF7;
    localparam logic [7:0] SPMS_ADDR_CTRL = 8'hF8;

    localparam logic [7:0] SPMS_RST_DATA = 8'h00;
    localparam logic [7:0] SPMS_RST_CTRL = 8'h04;

    localparam int SPMS_BIT_DONE = 7;
    localparam int SPMS_BIT_WRITE_COLLISION_FLAG = 6;
    localparam int SPMS_BIT_SPE = 5;
    localparam int SPMS_BIT_MSTR = 4;
    localparam int SPMS_BIT_CLOCK_IDLE_LEVEL = 3;
    localparam int SPMS_BIT_CLOCK_PHASE_SELECT = 2;
    localparam int SPMS_BIT_RATE_HI = 1;
    localparam int SPMS_BIT_RATE_LO = 0;

    // Serial clock edges in one byte: two per bit.
    localparam logic [3:0] SPMS_LAST_EDGE = 4'hF;
    localparam logic [3:0] SPMS_BITS_PER_BYTE = 4'h8;

    typedef enum logic {
        SPMS_IDLE,
        SPMS_RUN
    } spms_state_type;

endpackage

// ---- core/spms_port.sv ----
// Purpose: Byte-wide full-duplex SPI port selectable as master or slave, with its two registers.
// Assumes: Pins and register strobes are synchronous to CLK; the pin mux resolves the two-way pins.
// Notes: Received bytes pass a small buffer before reaching the data register, so a read never tears.

`timescale 1ns/1ps
`default_nettype none

//Contract
// - Done flag sets after each byte; cleared by writing it or reading data.
// - Writing data during a transfer sets the collision flag until software clears it.
// - Port-select bit gives the shared pins to SPI, else hands them to I2C.
// - Master-select set drives serial clock out; cleared makes it an input.
// - Clock idle level bit sets whether serial clock idles high or low.
// - Phase bit set launches on leading edge; cleared launches on trailing edge.
// - Master bit rate is core clock over 2, 4, 8 or 16 by code.
// - In slave mode the low rate bit reads back the slave-select pin.
// - Each master data write made while not busy produces exactly eight serial clock periods.
// - Master mode ignores the slave-select input entirely.
// - Master shifts a bit out on MOSI and samples MISO every period.
// - After eighth master clock, copy received byte to data and set done.
// - Slave write loads the byte to send; each clock moves one bit each way.
// - Slave byte ends after eighth clock at phase one, or select high at zero.
// - Slave copies byte and sets done only after the byte fully completes.
// - Polarity and phase must match at master and slave.
// - Data write gives next byte to send; read returns last received byte.
// - Each transfer moves one byte each way, most significant bit first.
module spms_port
    import spms_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input wire logic CLK, // Core clock, 200 MHz.
    input wire logic ARST_N, // Asynchronous reset, active low.
    input wire logic [7:0] SFR_ADDR, // Register address.
    input wire logic SFR_WR, // Register write strobe, one cycle.
    input wire logic SFR_RD, // Register read strobe, one cycle.
    input wire logic [7:0] SFR_WDATA, // Register write data.
    output logic [7:0] SFR_RDATA, // Read data, valid the cycle after the strobe.
    output logic IRQ_REQ, // Transfer-done request to the interrupt controller.
    output logic I2C_SEL, // High when the shared pins belong to I2C.
    input wire logic SCLK_I, // Serial clock pin level.
    output logic SCLK_O, // Serial clock drive value.
    output logic SCLK_OE, // Serial clock drive enable.
    input wire logic MOSI_I, // MOSI pin level.
    output logic MOSI_O, // MOSI drive value.
    output logic MOSI_OE, // MOSI drive enable.
    input wire logic MISO_I, // MISO pin level.
    output logic MISO_O, // MISO drive value.
    output logic MISO_OE, // MISO drive enable.
    input wire logic SS_N // Slave select, active low.
);

    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("BUF_DEPTH must be a power of two of at least two");
    end

    // Register state.
    logic [7:0] data_q, data_d, rdata_q, rdata_d;
    logic done_q, done_d, write_collision_flag_q, write_collision_flag_d, spe_q, spe_d, mstr_q, mstr_d, clock_idle_level_q, clock_idle_level_d, clock_phase_select_q, clock_phase_select_d;
    logic [1:0] rate_q, rate_d;

    // Engine state.
    spms_state_type state_q, state_d;
    logic pend_q, pend_d, out_q, out_d, sclk_q, sclk_d, sclk_prev_q;
    logic [7:0] tx_q, tx_d, rx_q, rx_d;
    logic [2:0] hc_q, hc_d;
    logic [3:0] edge_q, edge_d, bits_q, bits_d;
    logic sclk_oe_q, mosi_oe_q, miso_oe_q, i2c_q;

    // Receive buffer state.
    logic [7:0] buf_mem_q [BUF_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
    logic [PTR_W:0] cnt_q, cnt_d;

    logic wr_data, wr_ctrl, rd_data, rd_ctrl;
    logic busy, push, pop, buf_ready;
    logic [7:0] push_data;
    logic [2:0] half_m1;
    logic slave_act, s_edge, s_lead, s_sample, s_launch;

    assign wr_data = SFR_WR && SFR_ADDR == SPMS_ADDR_DATA;
    assign wr_ctrl = SFR_WR && SFR_ADDR == SPMS_ADDR_CTRL;
    assign rd_data = SFR_RD && SFR_ADDR == SPMS_ADDR_DATA;
    assign rd_ctrl = SFR_RD && SFR_ADDR == SPMS_ADDR_CTRL;

    // Master half period in core cycles is 1, 2, 4 or 8.
    assign half_m1 = 3'((4'h1 << rate_q) - 4'h1);

    assign busy = mstr_q ? (pend_q || state_q == SPMS_RUN) : (bits_q != 4'h0);
    assign buf_ready = cnt_q != (PTR_W + 1)'(BUF_DEPTH);
    // A data read in progress holds the data register still for that cycle.
    assign pop = cnt_q != '0 && !rd_data;

    assign slave_act = spe_q && !mstr_q && !SS_N;
    assign s_edge = slave_act && SCLK_I != sclk_prev_q;
    assign s_lead = SCLK_I != clock_idle_level_q;
    assign s_sample = s_edge && (s_lead == !clock_phase_select_q);
    assign s_launch = s_edge && (s_lead == clock_phase_select_q);

    always_comb begin
        data_d = data_q;
        done_d = done_q;
        write_collision_flag_d = write_collision_flag_q;
        spe_d = spe_q;
        mstr_d = mstr_q;
        clock_idle_level_d = clock_idle_level_q;
        clock_phase_select_d = clock_phase_select_q;
        rate_d = rate_q;
        rdata_d = 8'h00;
        if (wr_ctrl) begin
            done_d = SFR_WDATA[SPMS_BIT_DONE];
            write_collision_flag_d = SFR_WDATA[SPMS_BIT_WRITE_COLLISION_FLAG];
            spe_d = SFR_WDATA[SPMS_BIT_SPE];
            mstr_d = SFR_WDATA[SPMS_BIT_MSTR];
            clock_idle_level_d = SFR_WDATA[SPMS_BIT_CLOCK_IDLE_LEVEL];
            clock_phase_select_d = SFR_WDATA[SPMS_BIT_CLOCK_PHASE_SELECT];
            rate_d = SFR_WDATA[SPMS_BIT_RATE_HI:SPMS_BIT_RATE_LO];
        end
        if (rd_data) begin
            done_d = 1'b0;
            rdata_d = data_q;
        end else if (rd_ctrl) begin
            rdata_d = {done_q, write_collision_flag_q, spe_q, mstr_q, clock_idle_level_q, clock_phase_select_q, rate_q[1],
                       mstr_q ? rate_q[0] : SS_N};
        end
        if (wr_data && busy) begin
            write_collision_flag_d = 1'b1;
        end
        // Hardware sets win over a clear in the same cycle.
        if (pop) begin
            data_d = buf_mem_q[rd_ptr_q];
            done_d = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            data_q <= SPMS_RST_DATA;
            done_q <= SPMS_RST_CTRL[SPMS_BIT_DONE];
            write_collision_flag_q <= SPMS_RST_CTRL[SPMS_BIT_WRITE_COLLISION_FLAG];
            spe_q <= SPMS_RST_CTRL[SPMS_BIT_SPE];
            mstr_q <= SPMS_RST_CTRL[SPMS_BIT_MSTR];
            clock_idle_level_q <= SPMS_RST_CTRL[SPMS_BIT_CLOCK_IDLE_LEVEL];
            clock_phase_select_q <= SPMS_RST_CTRL[SPMS_BIT_CLOCK_PHASE_SELECT];
            rate_q <= SPMS_RST_CTRL[SPMS_BIT_RATE_HI:SPMS_BIT_RATE_LO];
            rdata_q <= 8'h00;
        end else begin
            data_q <= data_d;
            done_q <= done_d;
            write_collision_flag_q <= write_collision_flag_d;
            spe_q <= spe_d;
            mstr_q <= mstr_d;
            clock_idle_level_q <= clock_idle_level_d;
            clock_phase_select_q <= clock_phase_select_d;
            rate_q <= rate_d;
            rdata_q <= rdata_d;
        end
    end

    always_comb begin
        state_d = state_q;
        pend_d = pend_q;
        tx_d = tx_q;
        rx_d = rx_q;
        out_d = out_q;
        sclk_d = clock_idle_level_q;
        hc_d = hc_q;
        edge_d = edge_q;
        bits_d = bits_q;
        push = 1'b0;
        push_data = rx_q;
        if (!spe_q) begin
            // Port handed to I2C: abandon any byte in flight.
            state_d = SPMS_IDLE;
            pend_d = 1'b0;
            bits_d = 4'h0;
        end else if (mstr_q) begin
            bits_d = 4'h0;
            case (state_q)
                SPMS_IDLE: begin
                    if (wr_data && !pend_q) begin
                        tx_d = SFR_WDATA;
                        pend_d = 1'b1;
                    end
                    // The start waits for room so no received byte can be dropped.
                    if (pend_q && buf_ready) begin
                        pend_d = 1'b0;
                        state_d = SPMS_RUN;
                        out_d = tx_q[7];
                        hc_d = 3'h0;
                        edge_d = 4'h0;
                    end
                end
                SPMS_RUN: begin
                    sclk_d = sclk_q;
                    hc_d = hc_q + 3'h1;
                    if (hc_q == half_m1) begin
                        hc_d = 3'h0;
                        sclk_d = !sclk_q;
                        edge_d = edge_q + 4'h1;
                        // Even edges lead, odd edges trail.
                        if (edge_q[0] == clock_phase_select_q) begin
                            rx_d = {rx_q[6:0], MISO_I};
                        end else if (edge_q != SPMS_LAST_EDGE) begin
                            out_d = clock_phase_select_q ? tx_q[7] : tx_q[6];
                            tx_d = {tx_q[6:0], 1'b0};
                        end
                        if (edge_q == SPMS_LAST_EDGE) begin
                            state_d = SPMS_IDLE;
                            push = 1'b1;
                            push_data = rx_d;
                        end
                    end
                end
                default: begin
                    state_d = SPMS_IDLE;
                end
            endcase
        end else begin
            state_d = SPMS_IDLE;
            pend_d = 1'b0;
            if (wr_data && bits_q == 4'h0) begin
                tx_d = SFR_WDATA;
            end
            if (s_sample) begin
                rx_d = {rx_q[6:0], MOSI_I};
                bits_d = bits_q + 4'h1;
                if (clock_phase_select_q && bits_q == SPMS_BITS_PER_BYTE - 4'h1) begin
                    bits_d = 4'h0;
                    push = 1'b1;
                    push_data = rx_d;
                end
            end
            if (s_launch && (bits_q != 4'h0 || clock_phase_select_q)) begin
                out_d = clock_phase_select_q ? tx_q[7] : tx_q[6];
                tx_d = {tx_q[6:0], 1'b0};
            end else if (bits_q == 4'h0 && !wr_data) begin
                out_d = tx_q[7];
            end
            if (!clock_phase_select_q && SS_N && bits_q != 4'h0) begin
                // A short frame is discarded rather than reported.
                bits_d = 4'h0;
                push = bits_q == SPMS_BITS_PER_BYTE;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= SPMS_IDLE;
            pend_q <= 1'b0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            out_q <= 1'b0;
            sclk_q <= 1'b0;
            hc_q <= 3'h0;
            edge_q <= 4'h0;
            bits_q <= 4'h0;
            sclk_prev_q <= 1'b0;
            sclk_oe_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            miso_oe_q <= 1'b0;
            i2c_q <= 1'b1;
        end else begin
            state_q <= state_d;
            pend_q <= pend_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            out_q <= out_d;
            sclk_q <= sclk_d;
            hc_q <= hc_d;
            edge_q <= edge_d;
            bits_q <= bits_d;
            sclk_prev_q <= SCLK_I;
            sclk_oe_q <= spe_q && mstr_q;
            mosi_oe_q <= spe_q && mstr_q;
            miso_oe_q <= spe_q && !mstr_q && !SS_N;
            i2c_q <= !spe_q;
        end
    end

    always_comb begin
        cnt_d = cnt_q;
        if (push && buf_ready && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !(push && buf_ready)) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_mem_q[i] <= 8'h00;
            end
        end else begin
            cnt_q <= cnt_d;
            if (push && buf_ready) begin
                buf_mem_q[wr_ptr_q] <= push_data;
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    assign SFR_RDATA = rdata_q;
    assign IRQ_REQ = done_q;
    assign I2C_SEL = i2c_q;
    assign SCLK_O = sclk_q;
    assign SCLK_OE = sclk_oe_q;
    assign MOSI_O = out_q;
    assign MOSI_OE = mosi_oe_q;
    assign MISO_O = out_q;
    assign MISO_OE = miso_oe_q;

    // Helper counters watched only by the checks below.
    logic [4:0] chk_toggles_q;
    logic [3:0] chk_gap_q;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            chk_toggles_q <= 5'h00;
            chk_gap_q <= 4'h0;
        end else begin
            chk_toggles_q <= (state_q != SPMS_RUN) ? 5'h00 : chk_toggles_q + 5'(sclk_d != sclk_q);
            chk_gap_q <= (state_q != SPMS_RUN || sclk_d != sclk_q) ? 4'h0 : chk_gap_q + 4'h1;
        end
    end

    default clocking chk_cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    chk_done_on_copy: assert property (pop |=> done_q && data_q == $past(buf_mem_q[rd_ptr_q]))
        else $error("done flag or data not updated on copy");
    chk_read_clears: assert property (rd_data && !pop && !wr_ctrl |=> !done_q)
        else $error("data read did not clear done flag");
    chk_write_collision_flag_set: assert property (wr_data && busy |=> write_collision_flag_q)
        else $error("collision flag not set on busy write");
    chk_pins_released: assert property (!spe_q |=> I2C_SEL && !SCLK_OE && !MOSI_OE && !MISO_OE)
        else $error("shared pins still driven while handed to I2C");
    chk_sclk_dir: assert property (spe_q && mstr_q |=> SCLK_OE)
        else $error("master does not drive serial clock");
    chk_idle_level: assert property (state_q == SPMS_IDLE && $past(state_q == SPMS_IDLE) && $stable(clock_idle_level_q)
        |-> SCLK_O == clock_idle_level_q)
        else $error("serial clock not at idle level");
    chk_rate_gap: assert property (state_q == SPMS_RUN && sclk_d != sclk_q |-> chk_gap_q == {1'b0, half_m1})
        else $error("serial clock half period wrong");
    chk_burst_len: assert property (state_q == SPMS_RUN && state_d == SPMS_IDLE && spe_q && mstr_q
        |=> chk_toggles_q == 5'd16)
        else $error("master burst not eight clocks");
    chk_ss_readback: assert property (rd_ctrl && !mstr_q |=> SFR_RDATA[0] == $past(SS_N))
        else $error("select level not read back in slave mode");
    chk_slave_quiet: assert property (SS_N && $past(SS_N) && !mstr_q |-> !MISO_OE)
        else $error("unselected slave drives MISO");

    cov_master_byte: cover property (state_q == SPMS_RUN ##[1:200] pop);
    cov_slave_byte: cover property (!mstr_q && push);
    cov_collision: cover property (wr_data && busy);
    cov_buffer_full: cover property (cnt_q == (PTR_W + 1)'(BUF_DEPTH));

endmodule // spms_port

`default_nettype wire

// ---- dv/spms_peer.sv ----
// Purpose: Far-end SPI device: a slave answering the port, or a master driving it.
// Assumes: The bench calls its tasks; master pacing counts core clock cycles.
// Notes: Released lines show the inverse of their last value, so a stale bit cannot pass.

`timescale 1ns/1ps
`default_nettype none

module spms_peer (
    input wire logic clk, // Core clock for master pacing.
    input wire logic sclk, // Resolved serial clock.
    input wire logic mosi, // Resolved MOSI.
    input wire logic miso, // Resolved MISO.
    output logic miso_drv, // Answer bit as slave.
    output logic sclk_drv, // Clock as master.
    output logic mosi_drv, // Data as master.
    output logic ss_n_drv // Select as master, active low.
);
    logic clock_idle_level = 1'b0;
    logic clock_phase_select = 1'b0;
    logic slave_on = 1'b0;
    logic [7:0] tx_sh = 8'h00;
    logic [7:0] rx_sh = 8'h00;
    int edges = 0;

    initial begin
        miso_drv = 1'b0;
        sclk_drv = 1'b0;
        mosi_drv = 1'b0;
        ss_n_drv = 1'b1;
    end

    task automatic launch();
        miso_drv = tx_sh[7];
        tx_sh = {tx_sh[6:0], 1'b0};
    endtask

    task automatic slave_load(input logic [7:0] tx, input logic pol, input logic pha);
        clock_idle_level = pol;
        clock_phase_select = pha;
        tx_sh = tx;
        edges = 0;
        slave_on = 1'b1;
        if (!pha) launch();
    endtask

    // Polarity and phase are taken from slave_load, which the bench calls with the port's setting, so both ends pair edges alike.
    always @(sclk) begin
        if (slave_on && edges < 16) begin
            edges++;
            if ((sclk != clock_idle_level) ^ clock_phase_select) rx_sh = {rx_sh[6:0], mosi};
            else launch();
            if (edges == 16) miso_drv = ~miso_drv;
        end
    end

    task automatic hold_idle(input logic pol);
        slave_on = 1'b0;
        sclk_drv = pol;
    endtask

    // A short count aborts the byte by lifting select early.
    task automatic master_xfer(input logic [7:0] tx, input logic pha, input int bits, output logic [7:0] rx);
        rx = 8'h00;
        repeat (4) @(negedge clk);
        ss_n_drv = 1'b0;
        for (int i = 7; i > 7 - bits; i--) begin
            if (!pha) mosi_drv = tx[i];
            repeat (4) @(negedge clk);
            sclk_drv = ~sclk_drv;
            if (pha) mosi_drv = tx[i];
            else rx = {rx[6:0], miso};
            repeat (4) @(negedge clk);
            sclk_drv = ~sclk_drv;
            if (pha) rx = {rx[6:0], miso};
        end
        repeat (4) @(negedge clk);
        ss_n_drv = 1'b1;
        mosi_drv = ~mosi_drv;
    endtask
endmodule // spms_peer

`default_nettype wire

// ---- dv/spms_port_tb.sv ----
// Purpose: Self-checking bench for the SPI port in master and slave roles.
// Assumes: Inputs change on the falling edge; read data is taken the cycle after the strobe.
// Notes: Select is held low during the reset read so control bit 0 reads as zero.

`timescale 1ns/1ps
`default_nettype none

module spms_port_tb
    import spms_pkg::*;
;
    logic clk, arst_n, sfr_wr, sfr_rd, ss_tb;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic irq_req, i2c_sel, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic p_miso, p_sclk, p_mosi, p_ss_n;
    logic sclk_w, mosi_w, miso_w, ss_w;
    int bad_count = 0;
    int tests_run = 0;

    assign sclk_w = sclk_oe ? sclk_o : p_sclk;
    assign mosi_w = mosi_oe ? mosi_o : p_mosi;
    assign miso_w = miso_oe ? miso_o : p_miso;
    assign ss_w = ss_tb & p_ss_n;

    spms_port #(.BUF_DEPTH(2)) DUT (.CLK(clk), .ARST_N(arst_n), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
        .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .IRQ_REQ(irq_req), .I2C_SEL(i2c_sel),
        .SCLK_I(sclk_w), .SCLK_O(sclk_o), .SCLK_OE(sclk_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
        .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_N(ss_w));

    spms_peer peer (.clk(clk), .sclk(sclk_w), .mosi(mosi_w), .miso(miso_w), .miso_drv(p_miso),
        .sclk_drv(p_sclk), .mosi_drv(p_mosi), .ss_n_drv(p_ss_n));

    always #2.5 clk = ~clk;

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        sfr_addr = addr;
        sfr_wdata = data;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk);
        sfr_addr = addr;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        data = sfr_rdata;
    endtask

    task automatic check_reset();
        logic [7:0] got;
        sfr_read(SPMS_ADDR_CTRL, got);
        check(got, SPMS_RST_CTRL);
        sfr_read(SPMS_ADDR_DATA, got);
        check(got, SPMS_RST_DATA);
        sfr_read(8'hF9, got);
        check(got, 8'h00);
        check({6'h00, i2c_sel, sclk_oe}, 8'h02);
    endtask

    // One byte as master, with a colliding write and select toggling throughout.
    task automatic run_master(input logic [1:0] rate, input logic pol, input logic pha,
        input logic [7:0] tx, input logic [7:0] ans);
        logic [7:0] low;
        logic [7:0] got;
        logic prev;
        int toggles;
        int first;
        int last;
        int t;
        low = {4'h0, pol, pha, rate};
        sfr_write(SPMS_ADDR_CTRL, 8'h30 | low);
        // Drive enables and idle level follow the control register one cycle later.
        @(negedge clk);
        peer.slave_load(ans, pol, pha);
        check({5'h00, sclk_o, sclk_oe, mosi_oe}, {5'h00, pol, 2'b11});
        check({7'h00, i2c_sel}, 8'h00);
        sfr_write(SPMS_ADDR_DATA, tx);
        toggles = 0;
        first = 0;
        last = 0;
        prev = sclk_o;
        // The colliding write rides inside the loop so the first toggle at the fastest rate is not missed.
        sfr_addr = SPMS_ADDR_DATA;
        sfr_wdata = ~tx;
        for (t = 0; t < 400 && irq_req !== 1'b1; t++) begin
            @(negedge clk);
            sfr_wr = t == 0;
            if (sclk_o !== prev) begin
                toggles++;
                if (toggles == 1) first = t;
                last = t;
            end
            prev = sclk_o;
            ss_tb = t[0];
        end
        if (t == 400) begin
            bad_count++;
            complete_run();
        end
        check(8'(toggles), 8'h10);
        check(8'(last - first), 8'(15 << rate));
        check(8'(t - last), 8'h02);
        check({7'h00, sclk_o}, {7'h00, pol});
        check(peer.rx_sh, tx);
        sfr_read(SPMS_ADDR_CTRL, got);
        check(got, 8'hF0 | low);
        sfr_write(SPMS_ADDR_CTRL, 8'h30 | low);
        sfr_read(SPMS_ADDR_CTRL, got);
        check(got, 8'h30 | low);
        sfr_read(SPMS_ADDR_DATA, got);
        check(got, ans);
    endtask

    // One byte as slave; a short count lifts select early and must leave no result.
    task automatic run_slave(input logic pol, input logic pha, input logic [7:0] tx,
        input logic [7:0] ans, input int bits);
        logic [7:0] got;
        peer.hold_idle(pol);
        sfr_write(SPMS_ADDR_CTRL, {4'h2, pol, pha, 2'b00});
        sfr_read(SPMS_ADDR_CTRL, got);
        check(got, {4'h2, pol, pha, 2'b01});
        check({5'h00, sclk_oe, mosi_oe, miso_oe}, 8'h00);
        sfr_write(SPMS_ADDR_DATA, tx);
        peer.master_xfer(ans, pha, bits, got);
        check({7'h00, irq_req}, {7'h00, pha && bits == 8});
        repeat (3) @(negedge clk);
        check({7'h00, irq_req}, {7'h00, bits == 8});
        if (bits == 8) begin
            check(got, tx);
            sfr_read(SPMS_ADDR_DATA, got);
            check(got, ans);
            check({7'h00, irq_req}, 8'h00);
        end
    endtask

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        ss_tb = 1'b0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        check_reset();
        for (int i = 0; i < 4; i++) begin
            run_master(i[1:0], i[0], i[1], 8'h96 ^ 8'(i * 37), 8'h3C ^ 8'(i * 53));
        end
        ss_tb = 1'b1;
        run_slave(1'b0, 1'b1, 8'hC3, 8'h5A, 8);
        run_slave(1'b1, 1'b0, 8'h81, 8'h7E, 8);
        run_slave(1'b1, 1'b1, 8'h24, 8'hB1, 8);
        run_slave(1'b0, 1'b0, 8'h6D, 8'hE2, 5);
        complete_run();
    end
endmodule // spms_port_tb

`default_nettype wire
